// ---- logic/sensor_seq_params.svh ----
`ifndef SENSOR_SEQ_PARAMS_SVH
`define SENSOR_SEQ_PARAMS_SVH
// ==========================================================
// Register map
`define ADDR_SEQ_CTRL 4'h0
`define ADDR_PIX_COUNT 4'h1
`define ADDR_LINE_COUNT 4'h2
`define ADDR_EXPOSURE 4'h3
`define ADDR_COL_START 4'h4
`define ADDR_READ_ROW 4'h5
`define ADDR_RESET_ROW 4'h6
`define ADDR_ARRAY_CTRL 4'h7
`define ADDR_AMP_CTRL 4'h8
`define ADDR_OFS_COARSE 4'h9
`define ADDR_OFS_FINE 4'ha
`define ADDR_CONV_CTRL 4'hb
// ==========================================================
// Field positions in the sequencer control word
`define SEQ_SHUTTER 0
`define SEQ_FRAME_CAL 1
`define SEQ_LINE_CAL 2
`define SEQ_PRECHARGE 3
`define SEQ_COL_DIV_LO 4
`define SEQ_SNAP_DIV_LO 6
`define SEQ_MS_LEVEL_LO 8
`define SEQ_MS_ENABLE 10
`define SEQ_EXT_RESET 11
// ==========================================================
// Reset values: every register clears to zero
`define RST_12 12'h000
`define RST_11 11'h000
`define RST_8 8'h00
`define RST_7 7'h00
`define RST_3 3'h0
// ==========================================================
// Divider terminal counts, period minus one in pixel clocks
`define SNAP_DIV_32 8'h1f
`define SNAP_DIV_64 8'h3f
`define SNAP_DIV_128 8'h7f
`define SNAP_DIV_256 8'hff
`define COL_DIV_4 5'h03
`define COL_DIV_8 5'h07
`define COL_DIV_16 5'h0f
`define COL_DIV_32 5'h1f
`endif

// ---- logic/sensor_seq_pkg.sv ----
`include "sensor_seq_params.svh"
package sensor_seq_pkg;
  typedef enum logic [3:0] {
    PH_IDLE = 4'b0001,
    PH_EXPOSE = 4'b0010,
    PH_HOLD = 4'b0100,
    PH_READ = 4'b1000
  } phase_t;

  typedef struct packed {
    logic [11:0] seqCtrl;
    logic [11:0] pixCount;
    logic [11:0] lineCount;
    logic [11:0] exposure;
    logic [10:0] colStart;
    logic [10:0] readRow;
    logic [10:0] resetRow;
    logic [7:0] arrayCtrl;
    logic [6:0] ampCtrl;
    logic [6:0] ofsCoarse;
    logic [6:0] ofsFine;
    logic [2:0] convCtrl;
    phase_t phase;
    logic [7:0] snapPre;
    logic [4:0] colPre;
    logic [11:0] expCnt;
    logic [11:0] rowIdx;
    logic [11:0] pixCnt;
    logic readActive;
    logic firstRow;
    logic pixelValid;
    logic rowSync;
    logic lastLine;
    logic calFast;
    logic calSlow;
    logic globalReset;
    logic sampleAll;
    logic timeout;
    logic snapTick;
    logic colTick;
  } state_t;
endpackage

// ---- logic/sensor_sequencer_control_regs.sv ----
// How it works
// - Snapshot mode exposes all pixels together, then reads rows one by one.
// - Snapshot start resets whole array; stop samples all pixels into storage.
// - Snapshot start ignored during readout; frame start still opens readout during exposure.
// - Frame-start pulse begins readout of a new frame.
// - Each row-step during readout selects next row and starts its blanking and column sync.
// - Sequencer makes internal control pulses, timed by register contents.
// - Every register clears to zero at reset.
// - Sequencer bit 0: zero snapshot shutter, one rolling shutter.
// - Output amplifier calibrated in every row blanking.
// - Fast calibration completes in one pulse; slow gives small increments.
// - First row of frame uses frame cal mode; later rows line mode.
// - Bit 3 continuous precharge; bits 5:4 column, 7:6 snapshot granularity.
// - Bits 9:8 multislope level, bit 10 enable, bit 11 external level.
// - Pixel count twelve bits; column start eleven bits.
// - Array bits 0,1 test drive; bit 2 column, bit 5 row subsample.
// - Array bits 3,4 swap column pairs; bits 6,7 swap row pairs.
// - Amplifier bits 3:0 gain, 4 unity, 5 second output, 6 low standby.
// - Converter bit 0 low tristates, bit 1 low gamma, bit 2 inverts.
// - Snapshot tick period is 32, 64, 128 or 256 pixel clocks.
// - Column sequencer tick is pixel clock divided by 4, 8, 16 or 32.
// - Exposure ticks counted after start; timeout pulse when count equals exposure.
`timescale 1ns/1ps
`default_nettype none
`include "sensor_seq_params.svh"
module sensor_sequencer_control_regs (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic regWrEn,
  input wire logic [3:0] regAddr,
  input wire logic [11:0] regWrData,
  input wire logic frameStart,
  input wire logic rowStep,
  input wire logic snapStart,
  input wire logic snapStop,
  output logic exposing,
  output logic globalReset,
  output logic sampleAll,
  output logic expTimeout,
  output logic readActive,
  output logic rowSync,
  output logic pixelValid,
  output logic lastLine,
  output logic calFast,
  output logic calSlow,
  output logic snapshotTick,
  output logic columnTick,
  output logic shutterRolling,
  output logic continuous_precharge,
  output logic [1:0] multislopeLevel,
  output logic multislope_enable,
  output logic external_reset_level,
  output logic [11:0] pixel_count_value,
  output logic [11:0] line_count_value,
  output logic [10:0] columnStart,
  output logic [10:0] read_row_start_value,
  output logic [10:0] reset_row_start_value,
  output logic testEven,
  output logic testOdd,
  output logic column_subsample,
  output logic column_pair_swap_a,
  output logic column_pair_swap_b,
  output logic row_subsample,
  output logic row_pair_swap_a,
  output logic row_pair_swap_b,
  output logic [3:0] ampGain,
  output logic ampUnity,
  output logic ampSecondOut,
  output logic ampActive,
  output logic [6:0] offsetCoarse,
  output logic [6:0] offsetFine,
  output logic output_bus_drive,
  output logic gammaOn,
  output logic output_invert
);
  sensor_seq_pkg::state_t s_ff;
  sensor_seq_pkg::state_t nxt_s;
  logic [7:0] snapDiv;
  logic [4:0] colDiv;
  logic [11:0] expNext;

  // ==========================================================
  // Divider terminal counts
  always_comb begin
    case (s_ff.seqCtrl[`SEQ_SNAP_DIV_LO +: 2])
      2'b00: snapDiv = `SNAP_DIV_32;
      2'b01: snapDiv = `SNAP_DIV_64;
      2'b10: snapDiv = `SNAP_DIV_128;
      default: snapDiv = `SNAP_DIV_256;
    endcase
    case (s_ff.seqCtrl[`SEQ_COL_DIV_LO +: 2])
      2'b00: colDiv = `COL_DIV_4;
      2'b01: colDiv = `COL_DIV_8;
      2'b10: colDiv = `COL_DIV_16;
      default: colDiv = `COL_DIV_32;
    endcase
  end

  // ==========================================================
  // Next state
  always_comb begin
    nxt_s = s_ff;
    expNext = s_ff.expCnt + 12'h001;
    nxt_s.rowSync = 1'b0;
    nxt_s.lastLine = 1'b0;
    nxt_s.calFast = 1'b0;
    nxt_s.calSlow = 1'b0;
    nxt_s.globalReset = 1'b0;
    nxt_s.sampleAll = 1'b0;
    nxt_s.timeout = 1'b0;
    // Register port; reserved addresses fall through untouched
    if (regWrEn) begin
      case (regAddr)
        `ADDR_SEQ_CTRL: nxt_s.seqCtrl = regWrData;
        `ADDR_PIX_COUNT: nxt_s.pixCount = regWrData;
        `ADDR_LINE_COUNT: nxt_s.lineCount = regWrData;
        `ADDR_EXPOSURE: nxt_s.exposure = regWrData;
        `ADDR_COL_START: nxt_s.colStart = regWrData[10:0];
        `ADDR_READ_ROW: nxt_s.readRow = regWrData[10:0];
        `ADDR_RESET_ROW: nxt_s.resetRow = regWrData[10:0];
        `ADDR_ARRAY_CTRL: nxt_s.arrayCtrl = regWrData[7:0];
        `ADDR_AMP_CTRL: nxt_s.ampCtrl = regWrData[6:0];
        `ADDR_OFS_COARSE: nxt_s.ofsCoarse = regWrData[6:0];
        `ADDR_OFS_FINE: nxt_s.ofsFine = regWrData[6:0];
        `ADDR_CONV_CTRL: nxt_s.convCtrl = regWrData[2:0];
        default: nxt_s.convCtrl = s_ff.convCtrl;
      endcase
    end
    // Free-running prescalers; snapshot one restarts at exposure start
    nxt_s.snapTick = (s_ff.snapPre == snapDiv);
    nxt_s.snapPre = nxt_s.snapTick ? 8'h00 : s_ff.snapPre + 8'h01;
    nxt_s.colTick = (s_ff.colPre == colDiv);
    nxt_s.colPre = nxt_s.colTick ? 5'h00 : s_ff.colPre + 5'h01;
    // Snapshot shutter sequence
    case (s_ff.phase)
      sensor_seq_pkg::PH_IDLE: begin
        // Rolling mode never enters exposure; start is simply ignored
        if (snapStart && !s_ff.seqCtrl[`SEQ_SHUTTER] && !s_ff.readActive) begin
          nxt_s.phase = sensor_seq_pkg::PH_EXPOSE;
          nxt_s.globalReset = 1'b1;
          nxt_s.expCnt = 12'h000;
          nxt_s.snapPre = 8'h00;
          nxt_s.snapTick = 1'b0;
        end
      end
      sensor_seq_pkg::PH_EXPOSE: begin
        if (s_ff.snapTick) begin
          nxt_s.expCnt = expNext;
          nxt_s.timeout = (expNext == s_ff.exposure);
        end
        if (snapStop) begin
          nxt_s.phase = sensor_seq_pkg::PH_HOLD;
          nxt_s.sampleAll = 1'b1;
        end
      end
      sensor_seq_pkg::PH_HOLD: begin
        if (frameStart) begin
          nxt_s.phase = sensor_seq_pkg::PH_READ;
        end
      end
      sensor_seq_pkg::PH_READ: begin
        if (s_ff.lastLine) begin
          nxt_s.phase = sensor_seq_pkg::PH_IDLE;
        end
      end
      default: nxt_s.phase = sensor_seq_pkg::PH_IDLE;
    endcase
    // Row readout, common to both shutters
    if (frameStart) begin
      nxt_s.readActive = 1'b1;
      nxt_s.rowIdx = 12'h000;
      nxt_s.firstRow = 1'b1;
    end else if (rowStep && s_ff.readActive) begin
      nxt_s.rowSync = 1'b1;
      nxt_s.pixelValid = 1'b1;
      nxt_s.pixCnt = 12'h000;
      nxt_s.firstRow = 1'b0;
      // Calibration mode: frame bit on first row, line bit after
      if (s_ff.firstRow ? s_ff.seqCtrl[`SEQ_FRAME_CAL] : s_ff.seqCtrl[`SEQ_LINE_CAL]) begin
        nxt_s.calSlow = 1'b1;
      end else begin
        nxt_s.calFast = 1'b1;
      end
      if (s_ff.rowIdx == s_ff.lineCount) begin
        nxt_s.lastLine = 1'b1;
        nxt_s.readActive = 1'b0;
      end else begin
        nxt_s.rowIdx = s_ff.rowIdx + 12'h001;
      end
    end
    // Two pixels per cycle, so the count is half the window width
    if (s_ff.pixelValid && !s_ff.rowSync) begin
      if (s_ff.pixCnt == s_ff.pixCount) begin
        nxt_s.pixelValid = 1'b0;
      end else begin
        nxt_s.pixCnt = s_ff.pixCnt + 12'h001;
      end
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_ff <= '0;
      s_ff.phase <= sensor_seq_pkg::PH_IDLE;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // ==========================================================
  // Outputs straight from the state flops
  assign exposing = (s_ff.phase == sensor_seq_pkg::PH_EXPOSE);
  assign globalReset = s_ff.globalReset;
  assign sampleAll = s_ff.sampleAll;
  assign expTimeout = s_ff.timeout;
  assign readActive = s_ff.readActive;
  assign rowSync = s_ff.rowSync;
  assign pixelValid = s_ff.pixelValid;
  assign lastLine = s_ff.lastLine;
  assign calFast = s_ff.calFast;
  assign calSlow = s_ff.calSlow;
  assign snapshotTick = s_ff.snapTick;
  assign columnTick = s_ff.colTick;
  assign shutterRolling = s_ff.seqCtrl[`SEQ_SHUTTER];
  assign continuous_precharge = s_ff.seqCtrl[`SEQ_PRECHARGE];
  assign multislopeLevel = s_ff.seqCtrl[`SEQ_MS_LEVEL_LO +: 2];
  // Enable only meaningful under the snapshot shutter
  assign multislope_enable = s_ff.seqCtrl[`SEQ_MS_ENABLE] & ~s_ff.seqCtrl[`SEQ_SHUTTER];
  assign external_reset_level = s_ff.seqCtrl[`SEQ_EXT_RESET];
  assign pixel_count_value = s_ff.pixCount;
  assign line_count_value = s_ff.lineCount;
  assign columnStart = s_ff.colStart;
  assign read_row_start_value = s_ff.readRow;
  assign reset_row_start_value = s_ff.resetRow;
  assign testEven = s_ff.arrayCtrl[0];
  assign testOdd = s_ff.arrayCtrl[1];
  assign column_subsample = s_ff.arrayCtrl[2];
  assign column_pair_swap_a = s_ff.arrayCtrl[3];
  assign column_pair_swap_b = s_ff.arrayCtrl[4];
  assign row_subsample = s_ff.arrayCtrl[5];
  assign row_pair_swap_a = s_ff.arrayCtrl[6];
  assign row_pair_swap_b = s_ff.arrayCtrl[7];
  assign ampGain = s_ff.ampCtrl[3:0];
  assign ampUnity = s_ff.ampCtrl[4];
  assign ampSecondOut = s_ff.ampCtrl[5];
  assign ampActive = s_ff.ampCtrl[6];
  assign offsetCoarse = s_ff.ofsCoarse;
  assign offsetFine = s_ff.ofsFine;
  assign output_bus_drive = s_ff.convCtrl[0];
  assign gammaOn = ~s_ff.convCtrl[1];
  assign output_invert = s_ff.convCtrl[2];

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  chk_no_overlap: assert property (exposing |-> !s_ff.readActive || $rose(exposing))
    else $error("exposure overlaps readout");
  chk_start_reset: assert property (snapStart && !shutterRolling && !s_ff.readActive
      && s_ff.phase == sensor_seq_pkg::PH_IDLE |=> globalReset && exposing)
    else $error("snapshot start did not reset the array");
  chk_stop_sample: assert property (exposing && snapStop |=> sampleAll && !exposing)
    else $error("snapshot stop did not sample pixels");
  chk_rolling_idle: assert property (shutterRolling && !exposing |=> !exposing)
    else $error("rolling mode entered exposure");
  chk_row_cal: assert property (rowStep && s_ff.readActive && !frameStart
      |=> rowSync && (calFast ^ calSlow))
    else $error("row step without one calibration pulse");
  chk_first_cal: assert property (rowStep && s_ff.readActive && !frameStart && s_ff.firstRow
      |=> calSlow == $past(s_ff.seqCtrl[`SEQ_FRAME_CAL]))
    else $error("first row used wrong calibration mode");
  chk_frame_start: assert property (frameStart |=> readActive && s_ff.rowIdx == 12'h000)
    else $error("frame start did not open readout");
  chk_snap_period: assert property (snapshotTick && !$past(globalReset)
      && s_ff.seqCtrl[7:6] == 2'b00 && $stable(s_ff.seqCtrl) |=> !snapshotTick [*8])
    else $error("snapshot tick period too short");
  // A granularity rewrite inside the window legally moves the next tick
  chk_col_period: assert property (columnTick && s_ff.seqCtrl[5:4] == 2'b00
      && $stable(s_ff.seqCtrl) |-> ##4 (columnTick || s_ff.seqCtrl[5:4] != 2'b00))
    else $error("column tick period wrong");
  chk_timeout_cnt: assert property (expTimeout |-> s_ff.expCnt == s_ff.exposure)
    else $error("timeout at wrong count");
  chk_reserved_wr: assert property (regWrEn && regAddr[3:2] == 2'b11 |=> $stable(s_ff.convCtrl)
      && $stable(s_ff.seqCtrl) && $stable(s_ff.exposure))
    else $error("reserved address changed a register");
  chk_gamma_pol: assert property (gammaOn == !s_ff.convCtrl[1])
    else $error("gamma polarity wrong");

  // ==========================================================
  // Pulse widths
  // Strobes are single-cycle so the array drivers never see a stretched edge

  chk_reset_pulse: assert property (globalReset
      |=> !globalReset)
    else $error("array reset pulse too long");

  chk_sample_pulse: assert property (sampleAll
      |=> !sampleAll)
    else $error("sample pulse too long");

  chk_timeout_pulse: assert property (expTimeout
      |=> !expTimeout)
    else $error("timeout pulse too long");

  chk_tick_restart: assert property (globalReset
      |-> !snapshotTick)
    else $error("snapshot prescaler not restarted");

  // ==========================================================
  // Sequencing
  // Exposure may only end through the stop pin, never silently

  chk_expose_hold: assert property (exposing && !snapStop
      |=> exposing)
    else $error("exposure ended without stop");

  chk_read_no_start: assert property (s_ff.phase == sensor_seq_pkg::PH_READ && snapStart
      |=> !globalReset && !exposing)
    else $error("start accepted during readout");

  chk_read_to_idle: assert property (s_ff.phase == sensor_seq_pkg::PH_READ && lastLine
      |=> s_ff.phase == sensor_seq_pkg::PH_IDLE)
    else $error("readout did not return to idle");

  chk_first_flag: assert property (frameStart
      |=> s_ff.firstRow)
    else $error("frame start did not mark first row");

  // ==========================================================
  // Rows and calibration

  chk_ignored_row: assert property (rowStep && !s_ff.readActive && !frameStart
      |=> !rowSync)
    else $error("row step accepted outside frame");

  chk_last_closes: assert property (lastLine
      |-> !readActive)
    else $error("last line left readout open");

  chk_cal_one: assert property (!(calFast && calSlow))
    else $error("both calibration pulses together");

  chk_cal_sync: assert property ((calFast || calSlow)
      |-> rowSync)
    else $error("calibration outside row blanking");

  chk_later_cal: assert property (rowStep && s_ff.readActive && !frameStart && !s_ff.firstRow
      |=> calSlow == $past(s_ff.seqCtrl[`SEQ_LINE_CAL]))
    else $error("later row used wrong calibration mode");

  // The count stops on equality; a larger window simply runs longer
  chk_pix_stop: assert property (pixelValid && !rowSync && s_ff.pixCnt == s_ff.pixCount
      && !rowStep |=> !pixelValid)
    else $error("pixel window did not close");

  // ==========================================================
  // Register port

  chk_seq_write: assert property (regWrEn && regAddr == `ADDR_SEQ_CTRL
      |=> s_ff.seqCtrl == $past(regWrData))
    else $error("sequencer write lost");

  chk_col_write: assert property (regWrEn && regAddr == `ADDR_COL_START
      |=> columnStart == $past(regWrData[10:0]))
    else $error("column start write lost");

  chk_ms_rolling: assert property (shutterRolling
      |-> !multislope_enable)
    else $error("multislope enabled under rolling shutter");
endmodule
`default_nettype wire

// ---- dv/ctrl_model.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "sensor_seq_params.svh"
// ==========================================================
// Camera controller: sole driver of register writes and pulses
module ctrl_model (
  input wire logic clk,
  input wire logic rolling,
  output logic regWrEn,
  output logic [3:0] regAddr,
  output logic [11:0] regWrData,
  output logic frameStart,
  output logic rowStep,
  output logic snapStart,
  output logic snapStop
);
  // Pixel clock is the bench clock itself
  initial begin
    regWrEn = 1'b0;
    regAddr = 4'h0;
    regWrData = 12'h000;
    {frameStart, rowStep, snapStart, snapStop} = 4'h0;
  end
  // Idle address and data are inverted so stale values never look valid
  task automatic wr(input logic [3:0] a, input logic [11:0] d);
    @(posedge clk);
    #1;
    regWrEn = 1'b1;
    regAddr = a;
    regWrData = d;
    @(posedge clk);
    #1;
    regWrEn = 1'b0;
    regAddr = ~a;
    regWrData = ~d;
  endtask
  // One-cycle pulse on {frameStart, rowStep, snapStart, snapStop}, with snapStart and snapStop held low in rolling mode
  task automatic pulse(input logic [3:0] sel);
    if (rolling) sel[1:0] = 2'b00;
    @(posedge clk);
    #1;
    {frameStart, rowStep, snapStart, snapStop} = sel;
    @(posedge clk);
    #1;
    {frameStart, rowStep, snapStart, snapStop} = 4'h0;
  endtask
  // Full start-up load, issued before any frame or snapshot pulse
  task automatic load_defaults();
    wr(`ADDR_SEQ_CTRL, 12'h0c4);
    wr(`ADDR_PIX_COUNT, 12'h27f);
    wr(`ADDR_LINE_COUNT, 12'h1ff);
    wr(`ADDR_EXPOSURE, 12'h7ff);
    wr(`ADDR_COL_START, 12'h000);
    wr(`ADDR_READ_ROW, 12'h000);
    wr(`ADDR_RESET_ROW, 12'h000);
    wr(`ADDR_ARRAY_CTRL, 12'h000);
    wr(`ADDR_AMP_CTRL, 12'h050);
    wr(`ADDR_OFS_COARSE, 12'h040);
    wr(`ADDR_OFS_FINE, 12'h040);
    wr(`ADDR_CONV_CTRL, 12'h003);
  endtask
endmodule
`default_nettype wire

// ---- dv/test_sensor_sequencer_control_regs.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "sensor_seq_params.svh"
module test_sensor_sequencer_control_regs;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  wire logic regWrEn, frameStart, rowStep, snapStart, snapStop;
  wire logic [3:0] regAddr;
  wire logic [11:0] regWrData;
  logic [3:0] ampGain;
  logic [11:0] pixel_count_value, line_count_value;
  logic exposing, globalReset, sampleAll, expTimeout, readActive, rowSync, pixelValid;
  logic lastLine, calFast, calSlow, snapshotTick, columnTick, shutterRolling;
  logic continuous_precharge, multislope_enable, external_reset_level, testEven, testOdd;
  logic column_subsample, column_pair_swap_a, column_pair_swap_b, row_subsample;
  logic row_pair_swap_a, row_pair_swap_b, ampUnity, ampSecondOut, ampActive;
  logic output_bus_drive, gammaOn, output_invert;
  logic [1:0] multislopeLevel;
  logic [6:0] offsetCoarse, offsetFine;
  logic [10:0] columnStart, read_row_start_value, reset_row_start_value;
  int num_errors = 0;
  int checks = 0;

  always #2 clk = ~clk;

  sensor_sequencer_control_regs sensor_sequencer_control_regs_i (
    .clk, .sys_rst, .regWrEn, .regAddr, .regWrData, .frameStart, .rowStep,
    .snapStart, .snapStop, .exposing, .globalReset, .sampleAll, .expTimeout,
    .readActive, .rowSync, .pixelValid, .lastLine, .calFast, .calSlow,
    .snapshotTick, .columnTick, .shutterRolling, .continuous_precharge,
    .multislopeLevel, .multislope_enable, .external_reset_level,
    .pixel_count_value, .line_count_value, .columnStart, .read_row_start_value,
    .reset_row_start_value, .testEven, .testOdd, .column_subsample,
    .column_pair_swap_a, .column_pair_swap_b, .row_subsample, .row_pair_swap_a,
    .row_pair_swap_b, .ampGain, .ampUnity, .ampSecondOut, .ampActive,
    .offsetCoarse, .offsetFine, .output_bus_drive, .gammaOn, .output_invert);
  ctrl_model ctrl_model_i (.clk, .rolling(shutterRolling), .regWrEn, .regAddr, .regWrData,
    .frameStart, .rowStep, .snapStart, .snapStop);

  // ==========================================================
  // Shared helpers
  task automatic chk(input string name, input logic [11:0] seen, input logic [11:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic tick();
    @(posedge clk);
    #1;
  endtask
  // Syncs to one tick, then counts clocks to the next
  task automatic per(input bit col, input logic [11:0] exp);
    int n;
    n = 0;
    while ((col ? columnTick : snapshotTick) !== 1'b1 && n < 600) begin
      tick();
      n++;
    end
    n = 0;
    do begin
      tick();
      n++;
    end while ((col ? columnTick : snapshotTick) !== 1'b1 && n < 600);
    chk(col ? "columnTick period" : "snapshotTick period", n[11:0], exp);
  endtask
  // One row with pixel count 3: sync cycle plus counts 0..3, five valid cycles
  task automatic row(input logic f, input logic l);
    int n;
    ctrl_model_i.pulse(4'h4);
    chk("rowSync", rowSync, 1);
    chk("cal fast/slow", {calFast, calSlow}, {f, ~f});
    chk("lastLine", lastLine, l);
    n = 0;
    while (pixelValid === 1'b1 && n < 50) begin
      tick();
      n++;
    end
    chk("pixelValid cycles", n[11:0], 5);
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    chk("pixel count", pixel_count_value, 0);
    chk("amp", {ampActive, ampSecondOut, ampUnity, ampGain}, 0);
    chk("conv", {output_invert, gammaOn, output_bus_drive}, 3'b010);
    chk("shutter", shutterRolling, 0);
    $display("reset test done");
  endtask
  task automatic t_regs();
    logic [7:0] p;
    ctrl_model_i.load_defaults();
    chk("pix", pixel_count_value, 12'h27f);
    chk("lines", line_count_value, 12'h1ff);
    chk("seq", {continuous_precharge, shutterRolling}, 0);
    chk("amp", {ampActive, ampSecondOut, ampUnity, ampGain}, 12'h050);
    chk("ofs", {offsetCoarse, offsetFine}, 14'h2040);
    chk("conv", {output_invert, gammaOn, output_bus_drive}, 3'b001);
    for (int i = 0; i < 2; i++) begin
      p = i ? 8'h5a : 8'ha5;
      ctrl_model_i.wr(`ADDR_ARRAY_CTRL, {4'h0, p});
      chk("array", {row_pair_swap_b, row_pair_swap_a, row_subsample, column_pair_swap_b,
        column_pair_swap_a, column_subsample, testOdd, testEven}, p);
    end
    ctrl_model_i.wr(`ADDR_AMP_CTRL, 12'h02b);
    chk("amp", {ampActive, ampSecondOut, ampUnity, ampGain}, 12'h02b);
    ctrl_model_i.wr(`ADDR_CONV_CTRL, 12'h006);
    chk("conv", {output_invert, gammaOn, output_bus_drive}, 3'b100);
    ctrl_model_i.wr(`ADDR_SEQ_CTRL, 12'hb08);
    chk("seq", {external_reset_level, multislope_enable, multislopeLevel,
      continuous_precharge, shutterRolling}, 6'h2e);
    ctrl_model_i.wr(`ADDR_SEQ_CTRL, 12'h401);
    chk("ms rolling", {multislope_enable, shutterRolling}, 2'b01);
    ctrl_model_i.wr(`ADDR_SEQ_CTRL, 12'h400);
    chk("ms snapshot", {multislope_enable, shutterRolling}, 2'b10);
    ctrl_model_i.wr(`ADDR_PIX_COUNT, 12'hfff);
    ctrl_model_i.wr(`ADDR_COL_START, 12'hfff);
    chk("col start", columnStart, 12'h7ff);
    for (int a = 12; a < 16; a++) ctrl_model_i.wr(a[3:0], 12'h000);
    chk("reserved pix", pixel_count_value, 12'hfff);
    chk("reserved col", columnStart, 12'h7ff);
    for (int c = 0; c < 4; c++) begin
      // Rolling mode keeps the snapshot side idle while ticks are timed
      ctrl_model_i.wr(`ADDR_SEQ_CTRL, {4'h0, c[1:0], c[1:0], 4'h1});
      per(1, 12'(4 << c));
      per(0, 12'(32 << c));
    end
    $display("register test done");
  endtask
  task automatic t_read();
    ctrl_model_i.wr(`ADDR_PIX_COUNT, 12'h003);
    ctrl_model_i.wr(`ADDR_LINE_COUNT, 12'h002);
    ctrl_model_i.wr(`ADDR_SEQ_CTRL, 12'h003);
    ctrl_model_i.pulse(4'h4);
    chk("row outside frame", rowSync, 0);
    ctrl_model_i.pulse(4'h8);
    chk("readActive", readActive, 1);
    row(0, 0);
    row(1, 0);
    row(1, 1);
    chk("readActive end", readActive, 0);
    $display("readout test done");
  endtask
  task automatic t_snap();
    int n;
    ctrl_model_i.wr(`ADDR_SEQ_CTRL, 12'h000);
    ctrl_model_i.wr(`ADDR_EXPOSURE, 12'h00a);
    ctrl_model_i.pulse(4'h2);
    chk("globalReset", globalReset, 1);
    chk("exposing", exposing, 1);
    n = 1;
    while (expTimeout !== 1'b1 && n < 1000) begin
      tick();
      n++;
    end
    chk("timeout cycles", n inside {[318:324]}, 1);
    ctrl_model_i.pulse(4'h1);
    chk("sampleAll", {sampleAll, exposing}, 2'b10);
    ctrl_model_i.pulse(4'h8);
    ctrl_model_i.pulse(4'h2);
    chk("start in readout", {globalReset, exposing}, 0);
    row(1, 0);
    row(1, 0);
    row(1, 1);
    chk("readActive end", readActive, 0);
    $display("snapshot test done");
  endtask

  // ==========================================================
  // Sequence, watchdog and verdict
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    t_reset();
    t_regs();
    t_read();
    t_snap();
    stop_test();
  end
  // About thirty to fifty times the expected run length
  initial begin
    #200000;
    num_errors++;
    stop_test();
  end
endmodule
`default_nettype wire
